// File: common/bto_pkg.sv
// boundary test operations: constants, states, carrier types
// assumes a device-side scan chain sampled from a slow external test clock
package bto_pkg;
  localparam int CHAIN_W = 18;
  localparam int DATA_W  = 16;
  localparam int HALF_W  = 8;
  localparam int DIR_BIT = 17;
  localparam int OE_BIT  = 16;
  localparam int IR_W    = 8;
  localparam int CODE_W  = 7;
  localparam logic [IR_W-1:0] IR_CAPTURE = 8'h81;
  localparam logic [IR_W-1:0] IR_RESET   = 8'hFF;
  localparam logic [CODE_W-1:0] I_EXTEST_A   = 7'h00;
  localparam logic [CODE_W-1:0] I_EXTEST_B   = 7'h03;
  localparam logic [CODE_W-1:0] I_CLAMP      = 7'h07;
  localparam logic [CODE_W-1:0] I_RUN_TEST   = 7'h09;
  localparam logic [CODE_W-1:0] I_READ_NORM  = 7'h0A;
  localparam logic [CODE_W-1:0] I_READ_TEST  = 7'h0B;
  localparam logic [CODE_W-1:0] I_SELF_TEST  = 7'h0C;
  localparam logic [CODE_W-1:0] I_TOGGLE     = 7'h0D;
  localparam logic [CODE_W-1:0] I_CSCAN_NORM = 7'h0E;
  localparam logic [CODE_W-1:0] I_CSCAN_TEST = 7'h0F;
  localparam logic [DATA_W-1:0] A_CELLS      = 16'h00FF;
  localparam logic [DATA_W-1:0] TAPS16       = 16'hB400;
  localparam logic [HALF_W-1:0] TAPS8        = 8'hB8;
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CHAIN  = 8'h08;
  localparam logic [7:0] REG_SHADOW = 8'h0C;
  localparam int CTRL_TAP_RESET = 0;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;
  typedef enum logic [1:0] {
    OP_SAMPLE_TOGGLE = 2'b00, OP_PATTERN = 2'b01, OP_SIGNATURE = 2'b10, OP_COMBINED = 2'b11
  } bto_op_e;
  typedef enum logic [3:0] {
    ST_TLR = 4'h0, ST_RTI = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
    ST_SHF_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PAU_DR = 4'h6, ST_EX2_DR = 4'h7,
    ST_UPD_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'hA, ST_SHF_IR = 4'hB,
    ST_EX1_IR = 4'hC, ST_PAU_IR = 4'hD, ST_EX2_IR = 4'hE, ST_UPD_IR = 4'hF
  } bto_tap_e;
  typedef struct packed {
    logic [CHAIN_W-1:0] sh;
    logic [CHAIN_W-1:0] lat;
  } bto_chain_s;
endpackage

// File: rtl/bto_top.sv
// boundary test operations: tap, boundary cells, op select, axi4-lite view
// assumes tck/tms/tdi/pins are asynchronous and much slower than core_clk
`timescale 1ns/1ps
module bto_top
  import bto_pkg::*;
(
  input  wire logic                core_clk,       // system clock
  input  wire logic                rst_n,          // sync reset
  input  wire logic                ce,             // clock enable
  input  wire logic [7:0]          s_axi_awaddr,   // write address
  input  wire logic                s_axi_awvalid,  // write address valid
  output logic                     s_axi_awready,  // write address ready
  input  wire logic [31:0]         s_axi_wdata,    // write data
  input  wire logic [3:0]          s_axi_wstrb,    // byte strobes
  input  wire logic                s_axi_wvalid,   // write data valid
  output logic                     s_axi_wready,   // write data ready
  output logic [1:0]               s_axi_bresp,    // write response
  output logic                     s_axi_bvalid,   // response valid
  input  wire logic                s_axi_bready,   // response ready
  input  wire logic [7:0]          s_axi_araddr,   // read address
  input  wire logic                s_axi_arvalid,  // read address valid
  output logic                     s_axi_arready,  // read address ready
  output logic [31:0]              s_axi_rdata,    // read data
  output logic [1:0]               s_axi_rresp,    // read response
  output logic                     s_axi_rvalid,   // read valid
  input  wire logic                s_axi_rready,   // read ready
  input  wire logic                tck,            // test clock pin
  input  wire logic                tms,            // mode select pin
  input  wire logic                tdi,            // serial test in
  output logic                     tdo,            // serial test out
  output logic                     tdo_oe,         // tdo drive enable
  input  wire logic [HALF_W-1:0]   a_in,           // port a pin level
  output logic [HALF_W-1:0]        a_out,          // port a drive value
  output logic [HALF_W-1:0]        a_oe,           // port a drive enable
  input  wire logic [HALF_W-1:0]   b_in,           // port b pin level
  output logic [HALF_W-1:0]        b_out,          // port b drive value
  output logic [HALF_W-1:0]        b_oe,           // port b drive enable
  output logic [DATA_W-1:0]        core_in,        // values fed to internal logic
  output logic                     test_mode       // normal function inhibited
);
  logic [2:0]        tck_q;
  logic [1:0]        tms_q, tdi_q;
  logic [DATA_W-1:0] pin_q1, pin_q2;
  logic              t_rise, t_fall, tms_s, tdi_s;
  bto_tap_e          st;
  logic [IR_W-1:0]   ir_sh, ir;
  logic [CODE_W-1:0] code;
  bto_op_e           osr, osr_sh;
  logic              bp;
  bto_chain_s        chain;
  logic              ctrl_tap_reset;
  logic              is_read, is_self, is_toggle, is_cscan, is_run, is_bsr, is_test, dir, ops_on;
  logic [DATA_W-1:0] in_mask, out_mask, next_sh, upd_mask, lf16;
  logic [HALF_W-1:0] in8, out8, pin8, sig8, pat8;

  // first stage of each synchroniser only feeds the second
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tck_q  <= 3'h0;
      tms_q  <= 2'h3;
      tdi_q  <= 2'h3;
      pin_q1 <= 16'h0000;
      pin_q2 <= 16'h0000;
    end else if (ce) begin
      tck_q  <= {tck_q[1:0], tck};
      tms_q  <= {tms_q[0], tms};
      tdi_q  <= {tdi_q[0], tdi};
      pin_q1 <= {b_in, a_in};
      pin_q2 <= pin_q1;
    end
  end
  assign t_rise = ce & tck_q[1] & ~tck_q[2];
  assign t_fall = ce & ~tck_q[1] & tck_q[2];
  assign tms_s  = tms_q[1];
  assign tdi_s  = tdi_q[1];

  function automatic bto_tap_e tap_next(bto_tap_e s, logic m);
    case (s)
      ST_TLR:    tap_next = m ? ST_TLR : ST_RTI;
      ST_RTI:    tap_next = m ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: tap_next = m ? ST_EX1_DR : ST_SHF_DR;
      ST_SHF_DR: tap_next = m ? ST_EX1_DR : ST_SHF_DR;
      ST_EX1_DR: tap_next = m ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: tap_next = m ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: tap_next = m ? ST_UPD_DR : ST_SHF_DR;
      ST_SEL_IR: tap_next = m ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: tap_next = m ? ST_EX1_IR : ST_SHF_IR;
      ST_SHF_IR: tap_next = m ? ST_EX1_IR : ST_SHF_IR;
      ST_EX1_IR: tap_next = m ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: tap_next = m ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: tap_next = m ? ST_UPD_IR : ST_SHF_IR;
      ST_UPD_DR,
      ST_UPD_IR: tap_next = m ? ST_SEL_DR : ST_RTI;
      default:   tap_next = ST_TLR;
    endcase
  endfunction

  // state advances on the rising test clock edge only; ctrl_tap_reset forces ST_TLR on any ce cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st <= ST_TLR;
    end else if (ce && ctrl_tap_reset) begin
      st <= ST_TLR;
    end else if (t_rise) begin
      st <= tap_next(st, tms_s);
    end
  end

  assign code      = ir[CODE_W-1:0];
  assign is_read   = (code == I_READ_NORM) || (code == I_READ_TEST);
  assign is_self   = (code == I_SELF_TEST);
  assign is_toggle = (code == I_TOGGLE);
  assign is_cscan  = (code == I_CSCAN_NORM) || (code == I_CSCAN_TEST);
  assign is_run    = (code == I_RUN_TEST);
  assign is_bsr    = is_read || is_self;
  assign is_test   = code inside {I_EXTEST_A, I_EXTEST_B, I_CLAMP, I_RUN_TEST, I_READ_TEST,
                                  I_TOGGLE, I_CSCAN_TEST};
  assign ops_on    = (st == ST_RTI) && (is_run || is_toggle);
  assign dir       = chain.lat[DIR_BIT];
  assign in_mask   = dir ? A_CELLS : ~A_CELLS;
  assign out_mask  = ~in_mask;

  // next value of the 16 data cells for one rising edge in Run-Test/Idle
  always_comb begin
    lf16 = {chain.sh[DATA_W-2:0], ^(chain.sh[DATA_W-1:0] & TAPS16)};
    in8  = dir ? chain.sh[HALF_W-1:0] : chain.sh[DATA_W-1:HALF_W];
    out8 = dir ? chain.sh[DATA_W-1:HALF_W] : chain.sh[HALF_W-1:0];
    pin8 = dir ? pin_q2[HALF_W-1:0] : pin_q2[DATA_W-1:HALF_W];
    sig8 = {in8[HALF_W-2:0], ^(in8 & TAPS8)} ^ pin8;
    pat8 = {out8[HALF_W-2:0], ^(out8 & TAPS8)};
    upd_mask = 16'hFFFF;
    case (osr)
      OP_SAMPLE_TOGGLE: next_sh = (pin_q2 & in_mask) | (~chain.sh[DATA_W-1:0] & out_mask);
      OP_PATTERN:       next_sh = lf16;
      OP_SIGNATURE: begin
        next_sh  = lf16 ^ (pin_q2 & in_mask);
        upd_mask = in_mask;
      end
      OP_COMBINED:      next_sh = dir ? {pat8, sig8} : {sig8, pat8};
      default:          next_sh = chain.sh[DATA_W-1:0];
    endcase
    if (is_toggle) begin
      next_sh  = (chain.sh[DATA_W-1:0] & in_mask) | (~chain.sh[DATA_W-1:0] & out_mask);
      upd_mask = out_mask;
    end
  end

  // boundary cells: shift stages move on rise, shadow latches on fall
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      chain <= '0;
    end else if (t_rise) begin
      case (st)
        ST_CAP_DR: if (is_self) chain.sh <= ~chain.lat;
        ST_SHF_DR: if (is_bsr) chain.sh <= {tdi_s, chain.sh[CHAIN_W-1:1]};
        ST_RTI:    if (ops_on) chain.sh[DATA_W-1:0] <= next_sh;
        default:   chain.sh <= chain.sh;
      endcase
    end else if (t_fall) begin
      if (st == ST_UPD_DR && is_bsr) begin
        chain.lat <= chain.sh;
      end else if (ops_on) begin
        chain.lat[DATA_W-1:0] <= (chain.lat[DATA_W-1:0] & ~upd_mask) | (chain.sh[DATA_W-1:0] & upd_mask);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ir_sh <= IR_CAPTURE;
      ir    <= IR_RESET;
    end else if (t_rise) begin
      if (st == ST_CAP_IR) ir_sh <= IR_CAPTURE;
      else if (st == ST_SHF_IR) ir_sh <= {tdi_s, ir_sh[IR_W-1:1]};
    end else if (t_fall) begin
      if (st == ST_UPD_IR) ir <= ir_sh;
      else if (st == ST_TLR) ir <= IR_RESET;
    end
  end

  // operation select: own shift stage so a scan never disturbs a running op
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      osr    <= OP_SAMPLE_TOGGLE;
      osr_sh <= OP_SAMPLE_TOGGLE;
    end else if (t_rise && is_cscan) begin
      if (st == ST_CAP_DR) osr_sh <= osr;
      else if (st == ST_SHF_DR) osr_sh <= bto_op_e'({tdi_s, osr_sh[1]});
    end else if (t_fall && is_cscan && st == ST_UPD_DR) begin
      osr <= osr_sh;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bp <= 1'b0;
    end else if (t_rise && !is_bsr && !is_cscan) begin
      if (st == ST_CAP_DR) bp <= 1'b0;
      else if (st == ST_SHF_DR) bp <= tdi_s;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (t_fall) begin
      tdo_oe <= (st == ST_SHF_DR) || (st == ST_SHF_IR);
      if (st == ST_SHF_IR) tdo <= ir_sh[0];
      else if (is_bsr) tdo <= chain.sh[0];
      else if (is_cscan) tdo <= osr_sh[0];
      else tdo <= bp;
    end
  end

  // pins follow the shadow latches, which only move on a falling edge
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      a_out     <= 8'h00;
      b_out     <= 8'h00;
      a_oe      <= 8'h00;
      b_oe      <= 8'h00;
      core_in   <= 16'h0000;
      test_mode <= 1'b0;
    end else if (ce) begin
      a_out     <= chain.lat[HALF_W-1:0];
      b_out     <= chain.lat[DATA_W-1:HALF_W];
      a_oe      <= {HALF_W{is_test & ~chain.lat[OE_BIT] & ~dir}};
      b_oe      <= {HALF_W{is_test & ~chain.lat[OE_BIT] & dir}};
      core_in   <= chain.lat[DATA_W-1:0];
      test_mode <= is_test;
    end
  end

  logic        aw_have, w_have;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic        w_lane0;
  logic [31:0] rd_val;
  logic        rd_hit;

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (s_axi_araddr)
      REG_CTRL:   rd_val[CTRL_TAP_RESET] = ctrl_tap_reset;
      REG_STATUS: rd_val = {16'h0000, ir, 1'b0, is_test, osr, st};
      REG_CHAIN:  rd_val = {14'h0000, chain.sh};
      REG_SHADOW: rd_val = {14'h0000, chain.lat};
      default:    rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_awready  <= 1'b1;
      s_axi_wready   <= 1'b1;
      s_axi_bvalid   <= 1'b0;
      s_axi_bresp    <= RESP_OKAY;
      aw_have        <= 1'b0;
      w_have         <= 1'b0;
      aw_addr        <= 8'h00;
      w_data         <= 32'h0000_0000;
      w_lane0        <= 1'b0;
      ctrl_tap_reset <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_lane0      <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (aw_have && w_have && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr inside {REG_CTRL, REG_STATUS, REG_CHAIN, REG_SHADOW}) ? RESP_OKAY : RESP_DECERR;
        if (aw_addr == REG_CTRL && w_lane0) ctrl_tap_reset <= w_data[CTRL_TAP_RESET];
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_have       <= 1'b0;
        w_have        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_rti_rise;
    t_rise && st == ST_RTI && is_run;
  endsequence

  property p_read_hold;
    t_rise && st == ST_CAP_DR && is_read |=> $stable(chain.sh);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read capture changed chain");

  property p_self_inv;
    t_rise && st == ST_CAP_DR && is_self |=> chain.sh == ~$past(chain.lat);
  endproperty
  a_self_inv: assert property (p_self_inv) else $error("self test capture not inverted");

  property p_toggle_bp;
    t_rise && st == ST_CAP_DR && is_toggle |=> !bp;
  endproperty
  a_toggle_bp: assert property (p_toggle_bp) else $error("bypass not zero");

  property p_toggle_inputs;
    t_rise && st == ST_RTI && is_toggle |=>
      (chain.sh[DATA_W-1:0] & in_mask) == ($past(chain.sh[DATA_W-1:0]) & in_mask);
  endproperty
  a_toggle_inputs: assert property (p_toggle_inputs) else $error("input cells moved");

  property p_cscan_keep;
    t_rise && st == ST_CAP_DR && is_cscan |=> osr_sh == $past(osr) && $stable(osr);
  endproperty
  a_cscan_keep: assert property (p_cscan_keep) else $error("op select modified");

  property p_ctl_cells;
    t_rise && ops_on |=> $stable(chain.sh[CHAIN_W-1:DATA_W]);
  endproperty
  a_ctl_cells: assert property (p_ctl_cells) else $error("control cells touched");

  property p_sample_toggle;
    s_rti_rise ##0 osr == OP_SAMPLE_TOGGLE |=>
      (chain.sh[DATA_W-1:0] & out_mask) == (~$past(chain.sh[DATA_W-1:0]) & out_mask);
  endproperty
  a_sample_toggle: assert property (p_sample_toggle) else $error("outputs not inverted");

  property p_zero_seed;
    s_rti_rise ##0 osr == OP_PATTERN && chain.sh[DATA_W-1:0] == 16'h0000 |=> chain.sh[DATA_W-1:0] == 16'h0000;
  endproperty
  a_zero_seed: assert property (p_zero_seed) else $error("zero seed moved");

  property p_idle_no_op;
    t_rise && st != ST_RTI && st != ST_SHF_DR && st != ST_CAP_DR |=> $stable(chain.sh);
  endproperty
  a_idle_no_op: assert property (p_idle_no_op) else $error("cells moved outside op");

  property p_tdo_fall;
    $changed(tdo) |-> $past(t_fall);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo changed off falling edge");

  property p_tdo_oe;
    $changed(tdo_oe) |-> tdo_oe == (st == ST_SHF_DR || st == ST_SHF_IR);
  endproperty
  a_tdo_oe: assert property (p_tdo_oe) else $error("tdo enable outside shift");

  property p_one_port;
    a_oe[0] || b_oe[0] |-> test_mode && !(a_oe[0] && b_oe[0]);
  endproperty
  a_one_port: assert property (p_one_port) else $error("both ports driven");
endmodule

// File: tb/bto_ctl_model.sv
// test controller model: drives tck, tms and tdi frames and samples tdo
// assumes a 100 ns core_clk; tck runs at 800 ns and rests low between frames
`timescale 1ns/1ps
module bto_ctl_model (
  input  wire logic core_clk, // system clock
  input  wire logic tdo,      // serial test out
  output logic      tck,      // test clock
  output logic      tms,      // mode select
  output logic      tdi       // serial test in
);
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
  end
  // one tck period: tms and tdi move at the fall, tdo is taken at the rise
  task automatic cyc(input logic t, input logic d, output logic o);
    tms <= t;
    tdi <= d;
    repeat (4) @(posedge core_clk);
    o = tdo;
    tck <= 1'h1;
    repeat (4) @(posedge core_clk);
    tck <= 1'h0;
  endtask
  // from run-test/idle through one scan and back; tdi is inverted outside shifts
  task automatic scan(input logic ir, input int n, input logic [17:0] din, output logic [17:0] dout);
    logic o;
    dout = '0;
    cyc(1'h1, ~tdi, o);
    if (ir) cyc(1'h1, ~tdi, o);
    cyc(1'h0, ~tdi, o);
    cyc(1'h0, ~tdi, o);
    for (int i = 0; i < n; i++) begin
      cyc(i == n - 1, din[i], o);
      dout[i] = o;
    end
    cyc(1'h1, ~tdi, o);
    cyc(1'h0, ~tdi, o);
  endtask
endmodule

// File: tb/bto_top_tb.sv
// bench: axi4-lite access tasks plus scan sequences through the controller model
// assumes core_clk at 10 MHz and the model in bto_ctl_model
`timescale 1ns/1ps
module bto_top_tb;
  import bto_pkg::*;
  logic        core_clk = 1'h0, rst_n = 1'h0, ce = 1'h1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        tck, tms, tdi, tdo, tdo_oe, test_mode;
  logic [7:0]  a_in = 8'h5A, b_in = 8'h3C, a_out, a_oe, b_out, b_oe;
  logic [15:0] core_in;
  int          bad_count = 0, cmp_count = 0;
  localparam logic [17:0] SEED [5] = '{18'h2A5C3, 18'h2B00D, 18'h2C0DE, 18'h21234, 18'h20000};
  localparam logic [1:0]  OPS [5]  = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1};

  always #50 core_clk = ~core_clk;

  bto_top i_bto_top (
    .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .a_in(a_in), .a_out(a_out), .a_oe(a_oe),
    .b_in(b_in), .b_out(b_out), .b_oe(b_oe), .core_in(core_in), .test_mode(test_mode)
  );
  bto_ctl_model i_bto_ctl_model (.core_clk(core_clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));

  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, exp);
    chk(32'(r), 32'(RESP_OKAY));
  endtask
  task automatic ir(input logic [7:0] code);
    logic [17:0] o;
    i_bto_ctl_model.scan(1'h1, 8, 18'(code), o);
    chk(32'(o), 32'h81);
  endtask
  task automatic dr(input int n, input logic [17:0] din, output logic [17:0] dout);
    i_bto_ctl_model.scan(1'h0, n, din, dout);
  endtask
  // extra wait lets pins settle after the last fall
  task automatic idle(input int n);
    logic o;
    repeat (n) i_bto_ctl_model.cyc(1'h0, ~tdi, o);
    repeat (6) @(posedge core_clk);
  endtask
  function automatic logic [15:0] l16(input logic [15:0] v);
    return {v[14:0], ^(v & TAPS16)};
  endfunction
  function automatic logic [7:0] l8(input logic [7:0] v);
    return {v[6:0], ^(v & TAPS8)};
  endfunction

  initial begin
    logic [17:0] o;
    logic [15:0] e;
    logic [15:0] lat;
    logic [31:0] d;
    logic [1:0]  r;
    logic [1:0]  prev;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'h1;
    rdc(REG_STATUS, 32'h0000FF00);
    rd(8'h10, d, r);
    chk(32'(r), 32'(RESP_DECERR));
    chk(d, 32'h0);
    wr(REG_STATUS, 32'hFFFFFFFF, r);
    chk(32'(r), 32'(RESP_OKAY));
    wr(REG_CTRL, 32'h0, r);
    rdc(REG_STATUS, 32'h0000FF00);
    idle(1);
    ir({1'h0, I_READ_TEST});
    dr(18, SEED[0], o);
    dr(18, SEED[0], o);
    chk(32'(o), 32'(SEED[0]));
    rdc(REG_SHADOW, 32'(SEED[0]));
    rdc(REG_STATUS, 32'h00000B41);
    chk(32'({test_mode, a_oe, b_oe, b_out}), 32'({1'h1, 8'h00, 8'hFF, SEED[0][15:8]}));
    idle(3);
    rdc(REG_CHAIN, 32'(SEED[0]));
    ir({1'h0, I_SELF_TEST});
    dr(18, SEED[0], o);
    chk(32'(o ^ SEED[0]), 32'h0003FFFF);
    chk(32'(test_mode), 32'h0);
    prev = 2'h0;
    for (int i = 0; i < 5; i++) begin
      ir({1'h0, I_READ_TEST});
      dr(18, SEED[i], o);
      ir({1'h1, I_CSCAN_TEST});
      dr(2, 18'(OPS[i]), o);
      chk(32'(o), 32'(prev));
      prev = OPS[i];
      ir({1'h0, I_RUN_TEST});
      idle(5);
      e = SEED[i][15:0];
      repeat (5) begin
        case (OPS[i])
          2'h0: e = {~e[15:8], a_in};
          2'h1: e = l16(e);
          2'h2: e = l16(e) ^ {8'h00, a_in};
          default: e = {l8(e[15:8]), l8(e[7:0]) ^ a_in};
        endcase
      end
      // signature mode leaves the output shadows where the seed put them
      lat = (OPS[i] == 2'h2) ? {SEED[i][15:8], e[7:0]} : e;
      rdc(REG_CHAIN, 32'({SEED[i][17:16], e}));
      chk(32'({test_mode, core_in, b_out}), 32'({1'h1, lat, lat[15:8]}));
      chk(32'({a_oe, b_oe, a_out}), 32'({8'h00, 8'hFF, lat[7:0]}));
    end
    ir({1'h0, I_READ_TEST});
    dr(18, SEED[0], o);
    ir({1'h0, I_TOGGLE});
    a_in <= 8'hC3;
    dr(1, 18'h1, o);
    chk(32'(o), 32'h0);
    idle(2);
    e = {~SEED[0][15:8], SEED[0][7:0]};
    rdc(REG_CHAIN, 32'({SEED[0][17:16], e}));
    chk(32'({test_mode, core_in, b_out}), 32'({1'h1, e, e[15:8]}));
    // tck edges seen while ce is low are lost, so no toggle step here
    ce <= 1'h0;
    idle(1);
    ce <= 1'h1;
    rdc(REG_CHAIN, 32'({SEED[0][17:16], e}));
    rdc(REG_STATUS, 32'h00000D51);
    wr(REG_CTRL, 32'h1, r);
    chk(32'(r), 32'(RESP_OKAY));
    rdc(REG_CTRL, 32'h1);
    idle(1);
    rdc(REG_STATUS, 32'h0000FF10);
    chk(32'({test_mode, b_oe}), 32'h0);
    wr(REG_CTRL, 32'h0, r);
    test_done();
  end

  initial begin
    repeat (40000) @(posedge core_clk);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end
endmodule
